// ===== sbcs_top.sv
// Purpose: Six-bit compare converter control with AXI4-Lite registers.
// Assumes: 100 MHz aclk, synchronous active-low reset.
// Notes:   Software may drive single compares, or let the sequencer
//          run a full six-step binary search.
`timescale 1ns/100ps
module sbcs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        input_above,
  output logic [5:0]       compare_code,
  output logic             irq
);
  // ==========================================================
  // State
  // ==========================================================
  sbcs_pkg::sbcs_state_t st_q, st_d;
  logic [5:0]  code_q, code_d;
  logic [5:0]  res_code_q, res_code_d;
  logic [2:0]  trial_q, trial_d;
  logic        done_q, done_d;
  logic [1:0]  ist_q, ist_d;
  logic [1:0]  imsk_q, imsk_d;
  logic        irq_q, irq_d;
  logic        cmp_start;
  logic        cmp_active;
  logic        cmp_finish;
  logic        cmp_result;
  logic [5:0]  step_code;
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  rr_q, rr_d;
  logic [1:0]  br_q, br_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
  logic        wr_fire;
  logic        rd_fire;
  logic        ctl_cmp;
  logic        ctl_conv;
  logic        code_wr;

  sbcs_comparator i_sbcs_comparator (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (cmp_start),
    .input_above (input_above),
    .active      (cmp_active),
    .finish      (cmp_finish),
    .result      (cmp_result)
  );

  sbcs_seq_step i_sbcs_seq_step (
    .code      (code_q),
    .trial     (trial_q),
    .above     (cmp_result),
    .next_code (step_code)
  );

  // ==========================================================
  // AXI4-Lite handshakes
  // ==========================================================
  assign wr_fire = aw_q && w_q && !b_q;
  assign rd_fire = s_axi_arvalid && !r_q;

  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    b_d   = b_q;
    r_d   = r_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    br_d  = br_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = (awa_q == sbcs_pkg::OFS_CTRL || awa_q == sbcs_pkg::OFS_CODE ||
              awa_q == sbcs_pkg::OFS_IRQ_MSK ||
              awa_q == sbcs_pkg::OFS_BUFFER) ? sbcs_pkg::AXI_OKAY
                                             : sbcs_pkg::AXI_DECERR;
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (rd_fire) begin
      r_d = 1'b1;
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
    awrdy_d = !aw_d;
    wrdy_d  = !w_d;
    arrdy_d = !r_d;
  end

  // Write decode; a busy sequencer ignores code writes.
  always_comb begin
    ctl_cmp  = 1'b0;
    ctl_conv = 1'b0;
    code_wr  = 1'b0;
    if (wr_fire && ws_q[0]) begin
      if (awa_q == sbcs_pkg::OFS_CTRL) begin
        ctl_cmp  = wd_q[sbcs_pkg::CTRL_COMPARE];
        ctl_conv = wd_q[sbcs_pkg::CTRL_CONVERT];
      end
      if (awa_q == sbcs_pkg::OFS_CODE || awa_q == sbcs_pkg::OFS_BUFFER) begin
        code_wr = 1'b1;
      end
    end
  end

  // ==========================================================
  // Compare and sequencer control
  // ==========================================================
  always_comb begin
    st_d       = st_q;
    code_d     = code_q;
    trial_d    = trial_q;
    res_code_d = res_code_q;
    done_d     = done_q;
    cmp_start  = 1'b0;
    case (st_q)
      sbcs_pkg::SBCS_IDLE: begin
        if (code_wr) begin
          if (awa_q == sbcs_pkg::OFS_BUFFER) begin
            code_d = {wd_q[5:4], wd_q[3:0]};
          end else begin
            code_d = wd_q[5:0];
          end
        end
        if (ctl_conv) begin
          code_d    = sbcs_pkg::CODE_START;
          trial_d   = sbcs_pkg::BITS_LAST;
          done_d    = 1'b0;
          st_d      = sbcs_pkg::SBCS_SEQ;
          cmp_start = 1'b1;
        end else if (ctl_cmp) begin
          st_d      = sbcs_pkg::SBCS_CMP;
          cmp_start = 1'b1;
        end
      end
      sbcs_pkg::SBCS_CMP: begin
        if (cmp_finish) begin
          st_d = sbcs_pkg::SBCS_IDLE;
        end
      end
      sbcs_pkg::SBCS_SEQ: begin
        if (cmp_finish) begin
          code_d = step_code;
          if (trial_q == 3'h0) begin
            res_code_d = step_code;
            done_d     = 1'b1;
            st_d       = sbcs_pkg::SBCS_IDLE;
          end else begin
            trial_d   = trial_q - 3'h1;
            cmp_start = 1'b1;
          end
        end
      end
      default: begin
        st_d = sbcs_pkg::SBCS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Interrupts and read data
  // ==========================================================
  always_comb begin
    ist_d  = ist_q;
    imsk_d = imsk_q;
    if (rd_fire && s_axi_araddr == sbcs_pkg::OFS_IRQ_ST) begin
      ist_d = 2'h0;
    end
    if (cmp_finish && st_q == sbcs_pkg::SBCS_CMP) begin
      ist_d[sbcs_pkg::IRQ_CMP] = 1'b1;
    end
    if (cmp_finish && st_q == sbcs_pkg::SBCS_SEQ && trial_q == 3'h0) begin
      ist_d[sbcs_pkg::IRQ_CONV] = 1'b1;
    end
    if (wr_fire && ws_q[0] && awa_q == sbcs_pkg::OFS_IRQ_MSK) begin
      imsk_d = wd_q[1:0];
    end
    irq_d = |(ist_d & imsk_d);
  end

  always_comb begin
    rd_d = rd_q;
    rr_d = rr_q;
    if (rd_fire) begin
      rr_d = sbcs_pkg::AXI_OKAY;
      case (s_axi_araddr)
        sbcs_pkg::OFS_CTRL:    rd_d = 32'h0000_0000;
        sbcs_pkg::OFS_CODE:    rd_d = {26'h0, code_q};
        sbcs_pkg::OFS_BUFFER:  rd_d = {24'h0, 2'h0, code_q[5:4], code_q[3:0]};
        sbcs_pkg::OFS_STATUS:  rd_d = {28'h0, done_q,
                                       st_q == sbcs_pkg::SBCS_SEQ,
                                       cmp_result, cmp_active};
        sbcs_pkg::OFS_RESULT:  rd_d = {26'h0, res_code_q};
        sbcs_pkg::OFS_IRQ_ST:  rd_d = {30'h0, ist_q};
        sbcs_pkg::OFS_IRQ_MSK: rd_d = {30'h0, imsk_q};
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = sbcs_pkg::AXI_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= sbcs_pkg::SBCS_IDLE;
      code_q     <= sbcs_pkg::CODE_RESET;
      res_code_q <= sbcs_pkg::CODE_RESET;
      trial_q    <= 3'h0;
      done_q     <= 1'b0;
      ist_q      <= 2'h0;
      imsk_q     <= sbcs_pkg::IRQ_MSK_RESET;
      irq_q      <= 1'b0;
      aw_q       <= 1'b0;
      w_q        <= 1'b0;
      b_q        <= 1'b0;
      r_q        <= 1'b0;
      awa_q      <= 8'h00;
      wd_q       <= 32'h0000_0000;
      ws_q       <= 4'h0;
      rd_q       <= 32'h0000_0000;
      rr_q       <= 2'h0;
      br_q       <= 2'h0;
      awrdy_q    <= 1'b1;
      wrdy_q     <= 1'b1;
      arrdy_q    <= 1'b1;
    end else begin
      st_q       <= st_d;
      code_q     <= code_d;
      res_code_q <= res_code_d;
      trial_q    <= trial_d;
      done_q     <= done_d;
      ist_q      <= ist_d;
      imsk_q     <= imsk_d;
      irq_q      <= irq_d;
      aw_q       <= aw_d;
      w_q        <= w_d;
      b_q        <= b_d;
      r_q        <= r_d;
      awa_q      <= awa_d;
      wd_q       <= wd_d;
      ws_q       <= ws_d;
      rd_q       <= rd_d;
      rr_q       <= rr_d;
      br_q       <= br_d;
      awrdy_q    <= awrdy_d;
      wrdy_q     <= wrdy_d;
      arrdy_q    <= arrdy_d;
    end
  end

  // Ready is high while the holding slot is empty.
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign compare_code  = code_q;
  assign irq           = irq_q;

  a_seq_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == sbcs_pkg::SBCS_IDLE && ctl_conv) |=> (code_q == 6'h20))
    else $error("first code is not half scale");
  a_seq_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == sbcs_pkg::SBCS_SEQ && cmp_finish && trial_q == 3'h0)
      |=> (done_q && res_code_q == code_q))
    else $error("done or result not captured");
  a_next_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == sbcs_pkg::SBCS_SEQ && cmp_finish && trial_q != 3'h0)
      |=> code_q[trial_q] == 1'b1)
    else $error("next trial bit not set");
  a_trial_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == sbcs_pkg::SBCS_SEQ && cmp_finish)
      |=> code_q[$past(trial_q)] == $past(cmp_result))
    else $error("trial bit does not follow result");
  a_fixed_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == sbcs_pkg::SBCS_SEQ && cmp_finish && trial_q != 3'h0)
      |=> cmp_active)
    else $error("sequence did not continue");
  a_one_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == sbcs_pkg::SBCS_CMP && cmp_finish)
      |=> st_q == sbcs_pkg::SBCS_IDLE)
    else $error("single compare did not return idle");
endmodule : sbcs_top

// ===== sbcs_pkg.sv
// Purpose: Constants for the six-bit compare and successive approximation
//          sequencer.
// Assumes: 100 MHz aclk, AXI4-Lite register access, 32-bit data.
// Notes:   Every offset and timing count lives here, and every field except the buffer nibble split, which the top module codes itself.
// Functional notes
// - Six-bit compare code selects 64 compare steps.
// - Result flag is one when input above compare.
// - Active flag clears itself when comparison ends.
// - One comparison spans three instruction times.
// - One compare per operation; sequence drives search.
// - Code carried in transfer buffer nibble layout.
package sbcs_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CODE    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_RESULT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
  localparam logic [7:0] OFS_BUFFER  = 8'h18;
  // Control register fields.
  localparam int CTRL_COMPARE = 0;
  localparam int CTRL_CONVERT = 1;
  // Status register fields.
  localparam int ST_ACTIVE = 0;
  localparam int ST_RESULT = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_DONE   = 3;
  // Interrupt status fields.
  localparam int IRQ_CMP  = 0;
  localparam int IRQ_CONV = 1;
  localparam int CODE_W   = 6;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic [5:0] CODE_START = 6'h20;
  localparam logic [1:0] IRQ_MSK_RESET = 2'h0;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
  // Comparison time: three instruction times of 2 us each.
  localparam int CLK_MHZ       = 100;
  localparam int CMP_TIME_US   = 6;
  localparam int CMP_CYCLES    = CMP_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 10;
  localparam logic [CNT_W-1:0] CMP_LAST = 10'(CMP_CYCLES - 1);
  localparam logic [2:0] BITS_LAST = 3'h5;
  typedef enum logic [1:0] {
    SBCS_IDLE = 2'b00,
    SBCS_CMP  = 2'b01,
    SBCS_SEQ  = 2'b10
  } sbcs_state_t;
endpackage : sbcs_pkg

// ===== sbcs_comparator.sv
// Purpose: Comparison timer; holds active for the compare time.
// Assumes: Synchronous active-low reset.
// Notes:   Result is sampled at the final cycle of the compare window.
`timescale 1ns/100ps
module sbcs_comparator (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic       input_above,
  output logic            active,
  output logic            finish,
  output logic            result
);
  logic [sbcs_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic                       act_q, act_d;
  logic                       fin_q, fin_d;
  logic                       res_q, res_d;

  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    fin_d = 1'b0;
    res_d = res_q;
    if (act_q) begin
      if (cnt_q == sbcs_pkg::CMP_LAST) begin
        act_d = 1'b0;
        fin_d = 1'b1;
        res_d = input_above;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
    end else if (start) begin
      act_d = 1'b1;
      cnt_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      act_q <= 1'b0;
      fin_q <= 1'b0;
      res_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      fin_q <= fin_d;
      res_q <= res_d;
    end
  end

  assign active = act_q;
  assign finish = fin_q;
  assign result = res_q;

  a_active_span: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(act_q) |-> act_q [*8])
    else $error("active dropped too early");
  a_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (act_q && cnt_q == sbcs_pkg::CMP_LAST) |=> (!act_q && fin_q))
    else $error("active did not clear at compare end");
endmodule : sbcs_comparator

// ===== sbcs_seq_step.sv
// Purpose: One binary-search step on the compare code.
// Assumes: Pure combinational.
// Notes:   Clears the trial bit on a low result, then sets the next one.
`timescale 1ns/100ps
module sbcs_seq_step (
  input  wire logic [5:0] code,
  input  wire logic [2:0] trial,
  input  wire logic       above,
  output logic [5:0]      next_code
);
  always_comb begin
    next_code = code;
    if (!above) begin
      next_code[trial] = 1'b0;
    end
    if (trial != 3'h0) begin
      next_code[trial - 3'h1] = 1'b1;
    end
  end
endmodule : sbcs_seq_step

// ===== sbcs_analog_src.sv
// Purpose: Analog input source facing the compare converter.
// Assumes: Level is given in half steps of the compare voltage.
// Notes:   Even levels other than zero never tie with a compare voltage; level zero ties with code zero.
`timescale 1ns/100ps
module sbcs_analog_src (
  input  wire logic [5:0] compare_code,
  input  wire logic [7:0] level,
  output logic            input_above
);
  logic [7:0] vref2;
  // ==========================================================
  // Compare voltage
  // Code zero gives zero volts, otherwise code minus one half.
  assign vref2 = (compare_code == 6'h00) ? 8'h00 :
                 {1'b0, compare_code, 1'b0} - 8'h01;
  // High only while the input lies above the compare voltage.
  assign input_above = level > vref2;
endmodule : sbcs_analog_src

// ===== test_six_bit_compare_sar_sequencer.sv
// Purpose: Self-checking bench for the compare converter control.
// Assumes: AXI4-Lite master tasks; analog source model on the far side.
// Notes:   Each test ends with a line; the run ends in conclude.
`timescale 1ns/100ps
module test_six_bit_compare_sar_sequencer;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        input_above;
  logic [5:0]  compare_code;
  logic        irq;
  logic [7:0]  level = 8'h00;
  logic [31:0] rdat;
  logic [1:0]  rsp;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  sbcs_top i_sbcs_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .input_above(input_above),
    .compare_code(compare_code), .irq(irq)
  );

  sbcs_analog_src i_sbcs_analog_src (
    .compare_code(compare_code), .level(level), .input_above(input_above)
  );

  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ==========================================================
  // Checking and closing
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ==========================================================
  // Bus master
  // Each task first lets an edge pass, so a strobe is never set twice
  // in one time step.
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rdat, rsp);
    chk(rdat & m, e);
  endtask : rdc

  // ==========================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    conclude();
  end

  // ==========================================================
  // Tests
  initial begin
    int         t0;
    int         dur0;
    logic [5:0] e;
    logic [7:0] lv [5];
    lv = '{8'd0, 8'd42, 8'd90, 8'd126, 8'd200};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(sbcs_pkg::OFS_CODE, 32'h3F, {26'h0, sbcs_pkg::CODE_RESET});
    rdc(sbcs_pkg::OFS_IRQ_MSK, 32'h3, {30'h0, sbcs_pkg::IRQ_MSK_RESET});
    rd(8'h1C, rdat, rsp);
    chk(rsp, sbcs_pkg::AXI_DECERR);
    wr(8'h20, 32'h1, rsp);
    chk(rsp, sbcs_pkg::AXI_DECERR);
    wr(sbcs_pkg::OFS_BUFFER, 32'hFF, rsp);
    chk(rsp, sbcs_pkg::AXI_OKAY);
    rdc(sbcs_pkg::OFS_BUFFER, 32'hFF, 32'h3F);
    // A write without the low byte lane must leave the code alone.
    s_axi_wstrb <= 4'h0;
    wr(sbcs_pkg::OFS_CODE, 32'h15, rsp);
    s_axi_wstrb <= 4'hF;
    rdc(sbcs_pkg::OFS_CODE, 32'h3F, 32'h3F);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      level <= (i == 1) ? 8'd70 : 8'd60;
      wr(sbcs_pkg::OFS_CODE, 32'h20, rsp);
      chk(compare_code, 32'h20);
      wr(sbcs_pkg::OFS_CTRL, 32'h1, rsp);
      t0 = cyc;
      rdc(sbcs_pkg::OFS_STATUS, 32'h1, 32'h1);
      do rd(sbcs_pkg::OFS_STATUS, rdat, rsp);
      while (rdat[sbcs_pkg::ST_ACTIVE] !== 1'b0);
      chk(32'(cyc - t0 >= 595 && cyc - t0 <= 612), 32'h1);
      rdc(sbcs_pkg::OFS_STATUS, 32'h2, 32'(i) << 1);
      rdc(sbcs_pkg::OFS_IRQ_ST, 32'h1, 32'h1);
      rdc(sbcs_pkg::OFS_IRQ_ST, 32'h1, 32'h0);
    end
    $display("test single compare done");
    for (int i = 0; i < 5; i++) begin
      level <= lv[i];
      e = (lv[i] > 8'd126) ? 6'h3F : lv[i][6:1];
      if (i == 2) wr(sbcs_pkg::OFS_IRQ_MSK, 32'h2, rsp);
      wr(sbcs_pkg::OFS_CTRL, 32'h2, rsp);
      t0 = cyc;
      rdc(sbcs_pkg::OFS_STATUS, 32'h4, 32'h4);
      chk(compare_code, {26'h0, sbcs_pkg::CODE_START});
      do rd(sbcs_pkg::OFS_STATUS, rdat, rsp);
      while (rdat[sbcs_pkg::ST_DONE] !== 1'b1 || rdat[sbcs_pkg::ST_BUSY]);
      if (i == 0) dur0 = cyc - t0;
      chk(32'(cyc - t0), 32'(dur0));
      chk(32'(cyc - t0 >= 3595), 32'h1);
      rdc(sbcs_pkg::OFS_RESULT, 32'h3F, {26'h0, e});
      chk(irq, 32'(i >= 2));
      rdc(sbcs_pkg::OFS_IRQ_ST, 32'h2, 32'h2);
      repeat (2) @(posedge aclk);
      chk(irq, 32'h0);
    end
    rdc(sbcs_pkg::OFS_IRQ_MSK, 32'h3, 32'h2);
    $display("test conversion done");
    conclude();
  end
endmodule : test_six_bit_compare_sar_sequencer
